// [rtl/osrg_top.sv]
// Operation
// - condition bits show only what is present right now
// - every occurrence latches into its event bit
// - reading an event register returns it, then clears it
// - questionable enable register is writable and reads back
// - operation enable register is writable and reads back
// - preset clears both enable registers at once
// - operation condition and event read as weighted bit sums
// - questionable condition, event, enable read as weighted sums
// - operation bit 0 set while calibrating
// - operation bit 1 set while self-test runs
// - bits 3,4: channel initiated in single-shot, zero in continuous
// - bits 5,6: channel waiting for trigger, zero in continuous
// - bit 8 configuration change is event only, condition reads zero
// - bit 10 follows the remote lock
// - bit 13 follows any pending error
// - event bits hold until read or clear status; enables kept
// - questionable bits 0,1,5,8,9 carry their fault sources
// - enabled event bits form each group's summary output
module osrg_top (
  input logic clk_i,
  input logic reset_i,
  input logic ce_i,
  input logic calibrating_i,
  input logic self_test_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] continuous_initiate_mode_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] init_cmd_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] trigger_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] trig_count_done_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] chan_busy_i,
  input logic config_changed_i,
  input logic lock_held_i,
  input logic error_pending_i,
  input logic [osrg_pkg::NUM_CHAN-1:0] volt_overload_i,
  input logic loop_unlocked_i,
  input logic cal_error_i,
  input logic ext_ref_i,
  input logic cmd_valid_i,
  input osrg_pkg::osrg_cmd_t cmd_op_i,
  input logic [osrg_pkg::REG_W-1:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [osrg_pkg::REG_W-1:0] rsp_data_o,
  output logic oper_summary_o,
  output logic ques_summary_o
);
  osrg_grp_if op_if ();
  osrg_grp_if q_if ();

  logic take;
  logic [osrg_pkg::NUM_CHAN-1:0] chan_init;
  logic [osrg_pkg::NUM_CHAN-1:0] chan_wait;
  logic [osrg_pkg::REG_W-1:0] op_cond;
  logic [osrg_pkg::REG_W-1:0] op_pulse;
  logic [osrg_pkg::REG_W-1:0] q_cond;
  logic [osrg_pkg::REG_W-1:0] rd_mux;
  logic [osrg_pkg::REG_W-1:0] rsp_data_q;
  logic rsp_valid_q;

  // commands only count while the clock enable is high
  assign take = cmd_valid_i && ce_i;

  generate
    for (genvar ch = 0; ch < osrg_pkg::NUM_CHAN; ch++)
    begin : g_chan
      osrg_chan u_chan (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cont_mode_i(continuous_initiate_mode_i[ch]),
        .init_i(init_cmd_i[ch]),
        .trigger_i(trigger_i[ch]),
        .count_done_i(trig_count_done_i[ch]),
        .busy_i(chan_busy_i[ch]),
        .initiated_o(chan_init[ch]),
        .waiting_o(chan_wait[ch])
      );
    end
  endgenerate

  always_comb
  begin
    op_cond = osrg_pkg::REG_RESET;
    op_cond[osrg_pkg::OP_CAL_BIT] = calibrating_i;
    op_cond[osrg_pkg::OP_TEST_BIT] = self_test_i;
    op_cond[osrg_pkg::OP_INIT_BIT +: osrg_pkg::NUM_CHAN] = chan_init;
    op_cond[osrg_pkg::OP_WAIT_BIT +: osrg_pkg::NUM_CHAN] = chan_wait;
    op_cond[osrg_pkg::OP_LOCK_BIT] = lock_held_i;
    op_cond[osrg_pkg::OP_ERR_BIT] = error_pending_i;
  end

  always_comb
  begin
    // configuration change feeds the event side only
    op_pulse = osrg_pkg::REG_RESET;
    op_pulse[osrg_pkg::OP_CFG_BIT] = config_changed_i;
  end

  always_comb
  begin
    q_cond = osrg_pkg::REG_RESET;
    q_cond[osrg_pkg::Q_OVLD_BIT +: osrg_pkg::NUM_CHAN] = volt_overload_i;
    q_cond[osrg_pkg::Q_UNLOCK_BIT] = loop_unlocked_i;
    q_cond[osrg_pkg::Q_CALERR_BIT] = cal_error_i;
    q_cond[osrg_pkg::Q_EXTREF_BIT] = ext_ref_i;
  end

  assign op_if.cond = op_cond;
  assign op_if.pulse = op_pulse;
  assign q_if.cond = q_cond;
  assign q_if.pulse = osrg_pkg::REG_RESET;
  assign op_if.wdata = cmd_wdata_i;
  assign q_if.wdata = cmd_wdata_i;

  always_comb
  begin
    op_if.rd_evt = 1'b0;
    op_if.wr_en = 1'b0;
    op_if.preset = 1'b0;
    op_if.clr = 1'b0;
    q_if.rd_evt = 1'b0;
    q_if.wr_en = 1'b0;
    q_if.preset = 1'b0;
    q_if.clr = 1'b0;
    if (take)
    begin
      case (cmd_op_i)
        osrg_pkg::OSRG_RD_OP_EVT:
          op_if.rd_evt = 1'b1;
        osrg_pkg::OSRG_WR_OP_EN:
          op_if.wr_en = 1'b1;
        osrg_pkg::OSRG_RD_Q_EVT:
          q_if.rd_evt = 1'b1;
        osrg_pkg::OSRG_WR_Q_EN:
          q_if.wr_en = 1'b1;
        osrg_pkg::OSRG_PRESET:
        begin
          op_if.preset = 1'b1;
          q_if.preset = 1'b1;
        end
        osrg_pkg::OSRG_CLR_STATUS:
        begin
          op_if.clr = 1'b1;
          q_if.clr = 1'b1;
        end
        default:
        begin
          op_if.rd_evt = 1'b0;
        end
      endcase
    end
  end

  osrg_group #(
    .MASK(osrg_pkg::OP_MASK)
  ) u_op_grp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .bus(op_if.grp)
  );

  osrg_group #(
    .MASK(osrg_pkg::QUES_MASK)
  ) u_q_grp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .bus(q_if.grp)
  );

  // event reads sample the register in the same edge that clears it
  always_comb
  begin
    case (cmd_op_i)
      osrg_pkg::OSRG_RD_OP_COND:
        rd_mux = op_if.cond_rd;
      osrg_pkg::OSRG_RD_OP_EVT:
        rd_mux = op_if.evt_q;
      osrg_pkg::OSRG_RD_OP_EN:
        rd_mux = op_if.en_q;
      osrg_pkg::OSRG_RD_Q_COND:
        rd_mux = q_if.cond_rd;
      osrg_pkg::OSRG_RD_Q_EVT:
        rd_mux = q_if.evt_q;
      osrg_pkg::OSRG_RD_Q_EN:
        rd_mux = q_if.en_q;
      default:
        rd_mux = osrg_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rsp_valid_q <= 1'b0;
    else if (ce_i)
      rsp_valid_q <= cmd_valid_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rsp_data_q <= osrg_pkg::REG_RESET;
    else if (take)
      rsp_data_q <= rd_mux;
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;
  // summary is combinational so a masked-in event shows the same cycle
  assign oper_summary_o = op_if.summary;
  assign ques_summary_o = q_if.summary;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_cond_read;
    take && cmd_op_i == osrg_pkg::OSRG_RD_OP_COND
      |=> rsp_valid_o && rsp_data_o == $past(op_cond & osrg_pkg::OP_MASK);
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("op condition read wrong");

  property p_evt_clear;
    take && cmd_op_i == osrg_pkg::OSRG_RD_OP_EVT
      |=> rsp_data_o == $past(op_if.evt_q) && op_if.evt_q == $past(op_if.set);
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event read not destructive");

  property p_evt_latch;
    ce_i && $past(ce_i) && $rose(calibrating_i) |=> op_if.evt_q[osrg_pkg::OP_CAL_BIT];
  endproperty
  a_evt_latch: assert property (p_evt_latch) else $error("calibration event lost");

  property p_evt_hold;
    op_if.evt_q[osrg_pkg::OP_CAL_BIT] && !op_if.rd_evt && !op_if.clr
      |=> op_if.evt_q[osrg_pkg::OP_CAL_BIT];
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event bit dropped");

  property p_cls_keeps_en;
    take && cmd_op_i == osrg_pkg::OSRG_CLR_STATUS
      |=> op_if.en_q == $past(op_if.en_q) && q_if.en_q == $past(q_if.en_q)
          && op_if.evt_q == $past(op_if.set);
  endproperty
  a_cls_keeps_en: assert property (p_cls_keeps_en) else $error("clear status wrong");

  property p_preset;
    take && cmd_op_i == osrg_pkg::OSRG_PRESET
      |=> op_if.en_q == osrg_pkg::REG_RESET && q_if.en_q == osrg_pkg::REG_RESET;
  endproperty
  a_preset: assert property (p_preset) else $error("preset left enables set");

  property p_cfg_event;
    ce_i && config_changed_i
      |=> op_if.evt_q[osrg_pkg::OP_CFG_BIT] && !op_if.cond_rd[osrg_pkg::OP_CFG_BIT];
  endproperty
  a_cfg_event: assert property (p_cfg_event) else $error("config change bit wrong");

  property p_cont_zero;
    continuous_initiate_mode_i[0]
      |-> !op_cond[osrg_pkg::OP_INIT_BIT] && !op_cond[osrg_pkg::OP_WAIT_BIT];
  endproperty
  a_cont_zero: assert property (p_cont_zero) else $error("continuous channel flagged");

  property p_wait_in_init;
    op_cond[osrg_pkg::OP_WAIT_BIT] |-> op_cond[osrg_pkg::OP_INIT_BIT];
  endproperty
  a_wait_in_init: assert property (p_wait_in_init) else $error("waiting yet not initiated");

  property p_trig_clears_wait;
    ce_i && op_cond[osrg_pkg::OP_WAIT_BIT] && trigger_i[0] && !continuous_initiate_mode_i[0]
      |=> !op_cond[osrg_pkg::OP_WAIT_BIT] || continuous_initiate_mode_i[0];
  endproperty
  a_trig_clears_wait: assert property (p_trig_clears_wait) else $error("trigger not taken");

  property p_lock_err;
    op_if.cond_rd[osrg_pkg::OP_LOCK_BIT] == lock_held_i
      && op_if.cond_rd[osrg_pkg::OP_ERR_BIT] == error_pending_i;
  endproperty
  a_lock_err: assert property (p_lock_err) else $error("lock or error bit wrong");

  property p_en_write;
    take && cmd_op_i == osrg_pkg::OSRG_WR_OP_EN
      |=> op_if.en_q == ($past(cmd_wdata_i) & osrg_pkg::OP_MASK);
  endproperty
  a_en_write: assert property (p_en_write) else $error("op enable write wrong");

  property p_q_en_readback;
    take && cmd_op_i == osrg_pkg::OSRG_WR_Q_EN ##1 take && cmd_op_i == osrg_pkg::OSRG_RD_Q_EN
      |=> rsp_data_o == ($past(cmd_wdata_i, 2) & osrg_pkg::QUES_MASK);
  endproperty
  a_q_en_readback: assert property (p_q_en_readback) else $error("ques enable readback");

  property p_summary;
    oper_summary_o == |(op_if.evt_q & op_if.en_q);
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_reserved_zero;
    ((op_if.evt_q | op_if.en_q | op_if.cond_rd) & ~osrg_pkg::OP_MASK) == 16'h0000
      && ((q_if.evt_q | q_if.en_q | q_if.cond_rd) & ~osrg_pkg::QUES_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_q_cond_map;
    take && cmd_op_i == osrg_pkg::OSRG_RD_Q_COND
      |=> rsp_data_o == $past({6'h00, ext_ref_i, cal_error_i, 2'h0, loop_unlocked_i, 3'h0,
                               volt_overload_i});
  endproperty
  a_q_cond_map: assert property (p_q_cond_map) else $error("ques map wrong");

  property p_cal_test_read;
    take && cmd_op_i == osrg_pkg::OSRG_RD_OP_COND
      |=> rsp_data_o[1:0] == $past({self_test_i, calibrating_i});
  endproperty
  a_cal_test_read: assert property (p_cal_test_read) else $error("cal bit wrong");

  property p_q_evt_clear;
    take && cmd_op_i == osrg_pkg::OSRG_RD_Q_EVT
      |=> rsp_data_o == $past(q_if.evt_q) && q_if.evt_q == $past(q_if.set);
  endproperty
  a_q_evt_clear: assert property (p_q_evt_clear) else $error("ques event read");

  property p_cont_zero_ch2;
    continuous_initiate_mode_i[1]
      |-> !op_cond[osrg_pkg::OP_INIT_BIT + 1] && !op_cond[osrg_pkg::OP_WAIT_BIT + 1];
  endproperty
  a_cont_zero_ch2: assert property (p_cont_zero_ch2) else $error("channel two flagged");

  property p_cv_evt_read;
    take && cmd_op_i == osrg_pkg::OSRG_RD_OP_EVT && |op_if.evt_q;
  endproperty
  c_evt_read: cover property (p_cv_evt_read);

  property p_cv_wait_run;
    op_cond[osrg_pkg::OP_WAIT_BIT] ##1 !op_cond[osrg_pkg::OP_WAIT_BIT] && op_cond[osrg_pkg::OP_INIT_BIT];
  endproperty
  c_wait_run: cover property (p_cv_wait_run);

  property p_cv_summary;
    !oper_summary_o ##1 oper_summary_o;
  endproperty
  c_summary: cover property (p_cv_summary);
endmodule

// [rtl/osrg_pkg.sv]
package osrg_pkg;
  localparam int REG_W = 16;
  localparam int NUM_CHAN = 2;
  localparam int OP_CAL_BIT = 0;
  localparam int OP_TEST_BIT = 1;
  localparam int OP_INIT_BIT = 3;
  localparam int OP_WAIT_BIT = 5;
  localparam int OP_CFG_BIT = 8;
  localparam int OP_LOCK_BIT = 10;
  localparam int OP_ERR_BIT = 13;
  localparam int Q_OVLD_BIT = 0;
  localparam int Q_UNLOCK_BIT = 5;
  localparam int Q_CALERR_BIT = 8;
  localparam int Q_EXTREF_BIT = 9;
  localparam logic [REG_W-1:0] OP_MASK = 16'h257b;
  localparam logic [REG_W-1:0] QUES_MASK = 16'h0323;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  typedef enum logic [3:0] {
    OSRG_CMD_NOP,
    OSRG_RD_OP_COND,
    OSRG_RD_OP_EVT,
    OSRG_RD_OP_EN,
    OSRG_WR_OP_EN,
    OSRG_RD_Q_COND,
    OSRG_RD_Q_EVT,
    OSRG_RD_Q_EN,
    OSRG_WR_Q_EN,
    OSRG_PRESET,
    OSRG_CLR_STATUS
  } osrg_cmd_t;
  typedef enum logic [1:0] {
    OSRG_CH_IDLE,
    OSRG_CH_WAIT,
    OSRG_CH_RUN
  } osrg_chan_state_t;
endpackage

// [rtl/osrg_grp_if.sv]
interface osrg_grp_if;
  logic [osrg_pkg::REG_W-1:0] cond;
  logic [osrg_pkg::REG_W-1:0] pulse;
  logic rd_evt;
  logic clr;
  logic wr_en;
  logic preset;
  logic [osrg_pkg::REG_W-1:0] wdata;
  logic [osrg_pkg::REG_W-1:0] cond_rd;
  logic [osrg_pkg::REG_W-1:0] evt_q;
  logic [osrg_pkg::REG_W-1:0] en_q;
  logic [osrg_pkg::REG_W-1:0] set;
  logic summary;
  modport ctrl (output cond, pulse, rd_evt, clr, wr_en, preset, wdata,
                input cond_rd, evt_q, en_q, set, summary);
  modport grp (input cond, pulse, rd_evt, clr, wr_en, preset, wdata,
               output cond_rd, evt_q, en_q, set, summary);
endinterface

// [rtl/osrg_chan.sv]
module osrg_chan (
  input logic clk_i,
  input logic reset_i,
  input logic ce_i,
  input logic cont_mode_i,
  input logic init_i,
  input logic trigger_i,
  input logic count_done_i,
  input logic busy_i,
  output logic initiated_o,
  output logic waiting_o
);
  osrg_pkg::osrg_chan_state_t state_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_q <= osrg_pkg::OSRG_CH_IDLE;
    else if (ce_i)
    begin
      case (state_q)
        osrg_pkg::OSRG_CH_IDLE:
          if (init_i && !cont_mode_i)
            state_q <= osrg_pkg::OSRG_CH_WAIT;
        osrg_pkg::OSRG_CH_WAIT:
          if (cont_mode_i)
            state_q <= osrg_pkg::OSRG_CH_IDLE;
          else if (trigger_i)
            state_q <= osrg_pkg::OSRG_CH_RUN;
        osrg_pkg::OSRG_CH_RUN:
          // more triggers still owed: back to waiting
          if (cont_mode_i || (!busy_i && count_done_i))
            state_q <= osrg_pkg::OSRG_CH_IDLE;
          else if (!busy_i)
            state_q <= osrg_pkg::OSRG_CH_WAIT;
        default:
          state_q <= osrg_pkg::OSRG_CH_IDLE;
      endcase
    end
  end

  assign initiated_o = !cont_mode_i && (state_q != osrg_pkg::OSRG_CH_IDLE);
  assign waiting_o = !cont_mode_i && (state_q == osrg_pkg::OSRG_CH_WAIT);
endmodule

// [rtl/osrg_group.sv]
module osrg_group #(
  parameter logic [osrg_pkg::REG_W-1:0] MASK = 16'hffff
) (
  input logic clk_i,
  input logic reset_i,
  input logic ce_i,
  osrg_grp_if.grp bus
);
  logic [osrg_pkg::REG_W-1:0] prev_q;
  logic [osrg_pkg::REG_W-1:0] evt_q;
  logic [osrg_pkg::REG_W-1:0] evt_d;
  logic [osrg_pkg::REG_W-1:0] en_q;
  logic [osrg_pkg::REG_W-1:0] set;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      prev_q <= osrg_pkg::REG_RESET;
    else if (ce_i)
      prev_q <= bus.cond;
  end

  assign set = ((bus.cond & ~prev_q) | bus.pulse) & MASK;

  always_comb
  begin
    evt_d = evt_q;
    if (bus.rd_evt || bus.clr)
      evt_d = osrg_pkg::REG_RESET;
    // set wins so a read never swallows a fresh occurrence
    evt_d = evt_d | set;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      evt_q <= osrg_pkg::REG_RESET;
    else if (ce_i)
      evt_q <= evt_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      en_q <= osrg_pkg::REG_RESET;
    else if (ce_i && bus.preset)
      en_q <= osrg_pkg::REG_RESET;
    else if (ce_i && bus.wr_en)
      en_q <= bus.wdata & MASK;
  end

  assign bus.cond_rd = bus.cond & MASK;
  assign bus.evt_q = evt_q;
  assign bus.en_q = en_q;
  assign bus.set = set;
  assign bus.summary = |(evt_q & en_q);
endmodule

// [test/test_operation_status_register_group.sv]
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module test_operation_status_register_group;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] OPM = osrg_pkg::OP_MASK;
  localparam logic [15:0] QM = osrg_pkg::QUES_MASK;
  logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, calibrating_i = 1'b0, self_test_i = 1'b0;
  logic config_changed_i = 1'b0, lock_held_i = 1'b0, error_pending_i = 1'b0;
  logic loop_unlocked_i = 1'b0, cal_error_i = 1'b0, ext_ref_i = 1'b0, cmd_valid_i = 1'b0;
  logic [1:0] continuous_initiate_mode_i = 2'h0, init_cmd_i = 2'h0, trigger_i = 2'h0;
  logic [1:0] trig_count_done_i = 2'h0, chan_busy_i = 2'h0, volt_overload_i = 2'h0;
  osrg_pkg::osrg_cmd_t cmd_op_i = osrg_pkg::OSRG_CMD_NOP;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic rsp_valid_o, oper_summary_o, ques_summary_o;
  logic [15:0] rsp_data_o;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] r;
  logic [15:0] eo, eq, en_o, en_q;

  osrg_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .calibrating_i(calibrating_i),
    .self_test_i(self_test_i), .continuous_initiate_mode_i(continuous_initiate_mode_i),
    .init_cmd_i(init_cmd_i), .trigger_i(trigger_i), .trig_count_done_i(trig_count_done_i),
    .chan_busy_i(chan_busy_i), .config_changed_i(config_changed_i), .lock_held_i(lock_held_i),
    .error_pending_i(error_pending_i), .volt_overload_i(volt_overload_i),
    .loop_unlocked_i(loop_unlocked_i), .cal_error_i(cal_error_i), .ext_ref_i(ext_ref_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_wdata_i(cmd_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .oper_summary_o(oper_summary_o),
    .ques_summary_o(ques_summary_o));

  always #20 clk_i = ~clk_i;

  function automatic logic [15:0] op_cond_f(input logic cal, tst, lck, err);
    logic [15:0] v;
    v = 16'h0000;
    v[0] = cal;
    v[1] = tst;
    v[10] = lck;
    v[13] = err;
    return v;
  endfunction

  function automatic logic [15:0] q_cond_f(input logic [1:0] ov, input logic unl, cer, ext);
    logic [15:0] v;
    v = 16'h0000;
    v[1:0] = ov;
    v[5] = unl;
    v[8] = cer;
    v[9] = ext;
    return v;
  endfunction

  task automatic finish_test;
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // valid stays up between back-to-back commands; idle drops it
  task automatic cmd(input osrg_pkg::osrg_cmd_t op, input logic [15:0] wd,
                     input logic [15:0] exp);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_wdata_i = wd;
    @(posedge clk_i);
    #2;
    `CHK(rsp_valid_o, 1'b1)
    `CHK(rsp_data_o, exp)
  endtask

  task automatic idle(input int n);
    cmd_valid_i = 1'b0;
    repeat (n)
    begin
      @(posedge clk_i);
    end
    #2;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    void'($urandom(26));
    repeat (3)
    begin
      @(posedge clk_i);
    end
    #2;
    reset_i = 1'b0;
    idle(1);
    // codes 1 to 15, unknown ones included, answer zero out of reset
    for (int i = 1; i < 16; i++)
    begin
      cmd(osrg_pkg::osrg_cmd_t'(i[3:0]), 16'h0000, 16'h0000);
    end
    for (int i = 0; i < 7; i++)
    begin
      r = (i == 0) ? 32'hffffffff : $urandom;
      cmd(osrg_pkg::OSRG_WR_OP_EN, r[15:0], 16'h0000);
      cmd(osrg_pkg::OSRG_RD_OP_EN, 16'h0000, r[15:0] & OPM);
      cmd(osrg_pkg::OSRG_WR_Q_EN, r[31:16], 16'h0000);
      cmd(osrg_pkg::OSRG_RD_Q_EN, 16'h0000, r[31:16] & QM);
    end
    cmd(osrg_pkg::OSRG_WR_OP_EN, 16'hffff, 16'h0000);
    cmd(osrg_pkg::OSRG_WR_Q_EN, 16'hffff, 16'h0000);
    cmd(osrg_pkg::OSRG_PRESET, 16'h0000, 16'h0000);
    cmd(osrg_pkg::OSRG_RD_OP_EN, 16'h0000, 16'h0000);
    cmd(osrg_pkg::OSRG_RD_Q_EN, 16'h0000, 16'h0000);
    // frozen clock enable: command ignored, no answer; valid must be low before freezing
    idle(1);
    ce_i = 1'b0;
    cmd_valid_i = 1'b1;
    cmd_op_i = osrg_pkg::OSRG_WR_OP_EN;
    cmd_wdata_i = 16'hffff;
    @(posedge clk_i);
    #2;
    `CHK(rsp_valid_o, 1'b0)
    ce_i = 1'b1;
    cmd(osrg_pkg::OSRG_RD_OP_EN, 16'h0000, 16'h0000);
    for (int ch = 0; ch < 2; ch++)
    begin
      chan_busy_i[ch] = 1'b1;
      trig_count_done_i[ch] = 1'b0;
      init_cmd_i[ch] = 1'b1;
      idle(1);
      init_cmd_i[ch] = 1'b0;
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, 16'h0028 << ch);
      trigger_i[ch] = 1'b1;
      idle(1);
      trigger_i[ch] = 1'b0;
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, 16'h0008 << ch);
      chan_busy_i[ch] = 1'b0;
      trig_count_done_i[ch] = 1'b1;
      idle(2);
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, 16'h0000);
      continuous_initiate_mode_i[ch] = 1'b1;
      init_cmd_i[ch] = 1'b1;
      idle(1);
      init_cmd_i[ch] = 1'b0;
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, 16'h0000);
      continuous_initiate_mode_i[ch] = 1'b0;
      trig_count_done_i[ch] = 1'b0;
    end
    cmd(osrg_pkg::OSRG_CLR_STATUS, 16'h0000, 16'h0000);
    cmd(osrg_pkg::OSRG_RD_OP_EVT, 16'h0000, 16'h0000);
    repeat (16)
    begin
      r = $urandom;
      {calibrating_i, self_test_i, lock_held_i, error_pending_i} = r[3:0];
      {volt_overload_i, loop_unlocked_i, cal_error_i, ext_ref_i} = r[8:4];
      config_changed_i = r[9];
      eo = op_cond_f(r[3], r[2], r[1], r[0]);
      eq = q_cond_f(r[8:7], r[6], r[5], r[4]);
      // config pulse lands on this read edge yet never shows as a condition
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, eo);
      config_changed_i = 1'b0;
      cmd(osrg_pkg::OSRG_RD_Q_COND, 16'h0000, eq);
      eo[8] = r[9];
      {calibrating_i, self_test_i, lock_held_i, error_pending_i} = 4'h0;
      {volt_overload_i, loop_unlocked_i, cal_error_i, ext_ref_i} = 5'h00;
      en_o = 16'($urandom);
      en_q = 16'($urandom);
      cmd(osrg_pkg::OSRG_WR_OP_EN, en_o, 16'h0000);
      cmd(osrg_pkg::OSRG_WR_Q_EN, en_q, 16'h0000);
      `CHK(oper_summary_o, |(eo & en_o & OPM))
      `CHK(ques_summary_o, |(eq & en_q & QM))
      cmd(osrg_pkg::OSRG_RD_OP_COND, 16'h0000, 16'h0000);
      if (r[10])
      begin
        cmd(osrg_pkg::OSRG_CLR_STATUS, 16'h0000, 16'h0000);
        eo = 16'h0000;
        eq = 16'h0000;
      end
      cmd(osrg_pkg::OSRG_RD_OP_EVT, 16'h0000, eo);
      cmd(osrg_pkg::OSRG_RD_Q_EVT, 16'h0000, eq);
      cmd(osrg_pkg::OSRG_RD_OP_EVT, 16'h0000, 16'h0000);
      cmd(osrg_pkg::OSRG_RD_Q_EVT, 16'h0000, 16'h0000);
      cmd(osrg_pkg::OSRG_RD_Q_EN, 16'h0000, en_q & QM);
    end
    // rise on the very edge of a destructive read must survive it
    calibrating_i = 1'b1;
    cmd(osrg_pkg::OSRG_RD_OP_EVT, 16'h0000, 16'h0000);
    cmd(osrg_pkg::OSRG_RD_OP_EVT, 16'h0000, 16'h0001);
    calibrating_i = 1'b0;
    idle(2);
    finish_test();
  end
endmodule
